// [serial_prog_pkg.sv]
// Purpose: Shared constants and types of the serial program/verify port
// Assumes: 250 MHz ref_clk, 14-bit memory words, 16-bit address space
// Notes: Addresses from 16'h8000 up are configuration space
package serial_prog_pkg;

	localparam int CLK_MHZ = 250;

	// Erase and program times, longest times round down to cycles
	localparam real BULK_ERASE_TIME_MS = 5.0;
	localparam real ROW_ERASE_TIME_MS = 2.5;
	localparam real PROG_TIME_MS = 2.5;
	localparam int BULK_ERASE_CYCLES = int'($floor(BULK_ERASE_TIME_MS * 1000.0 * CLK_MHZ));
	localparam int ROW_ERASE_CYCLES = int'($floor(ROW_ERASE_TIME_MS * 1000.0 * CLK_MHZ));
	localparam int PROG_CYCLES = int'($floor(PROG_TIME_MS * 1000.0 * CLK_MHZ));
	localparam int BUSY_W = 21;

	localparam int ADDR_W = 16;
	localparam int WORD_W = 14;
	localparam int CMD_W = 6;
	localparam logic [4:0] FRAME_LAST_FALL = 5'h0f;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0e;

	// Address map
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] CFG_BASE = 16'h8000;
	localparam logic [15:0] DEV_ID_ADDR = 16'h8006;
	localparam logic [15:0] CFG_WORD1_ADDR = 16'h8007;
	localparam logic [15:0] CAL_LAST_ADDR = 16'h800a;
	localparam int CFG_SPACE_BIT = 15;
	localparam int CP_N_POS = 7;
	localparam logic CP_N_RESET = 1'b1;

	// Command codes, top bit of the six is don't care
	localparam logic [4:0] CMD_LOAD_CFG = 5'h00;
	localparam logic [4:0] CMD_LOAD_DATA = 5'h02;
	localparam logic [4:0] CMD_READ_DATA = 5'h04;
	localparam logic [4:0] CMD_INC_ADDR = 5'h06;
	localparam logic [4:0] CMD_RESET_ADDR = 5'h16;
	localparam logic [4:0] CMD_BEGIN_INT = 5'h08;
	localparam logic [4:0] CMD_BEGIN_EXT = 5'h18;
	localparam logic [4:0] CMD_END_EXT = 5'h0a;
	localparam logic [4:0] CMD_BULK_ERASE = 5'h09;
	localparam logic [4:0] CMD_ROW_ERASE = 5'h11;

	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_DATA = 2'b01,
		ST_BUSY = 2'b11
	} state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wrData;
		logic write;
		logic bulkErase;
		logic rowErase;
	} nvm_req_s;

	typedef struct packed {
		logic [WORD_W-1:0] rdData;
		logic cpNStored;
	} nvm_rsp_s;

	typedef struct packed {
		state_e st;
		logic clkPrev;
		logic [CMD_W-1:0] cmdSh;
		logic [4:0] cnt;
		logic [WORD_W-1:0] dataSh;
		logic isRead;
		logic loadCfg;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] latch;
		logic cpN;
		logic cpLoaded;
		logic extActive;
		logic [BUSY_W-1:0] busyCnt;
		logic dOut;
		logic dOe;
		nvm_req_s req;
	} core_s;

endpackage

// [sync_2ff.sv]
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Synchronous active-low reset
// Notes: Only the second stage may be read by other logic
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;

endmodule

// [serial_prog_port.sv]
// Purpose: Serial program/verify command engine facing an external programmer
// Assumes: Programmer clock far slower than ref_clk; memory answers rdData combinationally
// Notes: Low progModeActive holds the block in reset, as mode entry does
//
// Function
// - Load-configuration sets address to 8000h and latches the following data word.
// - Externally timed writes never change configuration or calibration words.
// - After configuration access, address returns to 0 only by reset-address or exit.
// - Load-data latches one 14-bit word; written only by a later begin command.
// - Read shifts out the addressed word from the second rising edge on.
// - Read drives the data pin from first falling edge until the 16th.
// - Protected program memory reads back as all zeros.
// - Protected program memory refuses programming.
// - User ID and configuration words stay writable and readable under protection.
// - Programming the active-low protect bit to zero turns protection on.
// - Only bulk erase clears protection; programmer must issue it.
// - Bulk erase finishes within 5 ms; programmer waits that long.
// - Row erase finishes within 2.5 ms; programmer waits that long.
// - Every command word is six bits.
// - Data frame is 16 clocks: start bit, 14 data bits, stop bit.
// - Load-config 00h, load-data 02h, read 04h each carry a data frame.
// - Begin-internal 08h, begin-external 18h, reset-address 16h carry no frame.
module serial_prog_port #(
	parameter int BULK_CYCLES = serial_prog_pkg::BULK_ERASE_CYCLES,
	parameter int ROW_CYCLES = serial_prog_pkg::ROW_ERASE_CYCLES,
	parameter int PROG_CYCLES = serial_prog_pkg::PROG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic progModeActive,
	input wire logic serialProgClockPin,
	input wire logic serialProgDataPinIn,
	output logic serialProgDataPinOut,
	output logic serialProgDataPinOe,
	output logic progBusy,
	output serial_prog_pkg::nvm_req_s nvmReq,
	input serial_prog_pkg::nvm_rsp_s nvmRsp
);

	localparam logic [serial_prog_pkg::BUSY_W-1:0] BULK_LOAD = serial_prog_pkg::BUSY_W'(BULK_CYCLES - 1);
	localparam logic [serial_prog_pkg::BUSY_W-1:0] ROW_LOAD = serial_prog_pkg::BUSY_W'(ROW_CYCLES - 1);
	localparam logic [serial_prog_pkg::BUSY_W-1:0] PROG_LOAD = serial_prog_pkg::BUSY_W'(PROG_CYCLES - 1);

	serial_prog_pkg::core_s cur_ff;
	serial_prog_pkg::core_s nxt_cur;
	logic [2:0] pinSync;
	logic clkS;
	logic dataS;
	logic modeS;
	logic coreRst;
	logic clkRise;
	logic clkFall;
	logic [4:0] cmdCode;
	logic protect;
	logic inProgSpace;
	logic cfgLocked;
	logic intWriteOk;
	logic extWriteOk;

	sync_2ff #(
		.WIDTH(3)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.asyncIn({progModeActive, serialProgDataPinIn, serialProgClockPin}),
		.syncOut(pinSync)
	);

	assign clkS = pinSync[0];
	assign dataS = pinSync[1];
	assign modeS = pinSync[2];
	// Leaving program/verify mode resets everything, address included
	assign coreRst = !rst_n || !modeS;
	assign clkRise = clkS && !cur_ff.clkPrev;
	assign clkFall = !clkS && cur_ff.clkPrev;

	// Top bit of the six-bit command is don't care
	assign cmdCode = nxt_cmdShift(cur_ff.cmdSh, dataS);
	assign protect = !cur_ff.cpN;
	assign inProgSpace = !cur_ff.addr[serial_prog_pkg::CFG_SPACE_BIT];
	// Configuration and calibration words, device ID is read-only anyway
	assign cfgLocked = cur_ff.addr >= serial_prog_pkg::CFG_WORD1_ADDR
		&& cur_ff.addr <= serial_prog_pkg::CAL_LAST_ADDR;
	assign intWriteOk = (inProgSpace && !protect)
		|| (!inProgSpace && cur_ff.addr != serial_prog_pkg::DEV_ID_ADDR);
	assign extWriteOk = intWriteOk && !cfgLocked;

	function automatic logic [4:0] nxt_cmdShift(input logic [5:0] sh, input logic bitIn);
		logic [5:0] full;
		full = {bitIn, sh[5:1]};
		return full[4:0];
	endfunction

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.clkPrev = clkS;
		nxt_cur.req.write = 1'b0;
		nxt_cur.req.bulkErase = 1'b0;
		nxt_cur.req.rowErase = 1'b0;
		nxt_cur.req.addr = cur_ff.addr;
		nxt_cur.req.wrData = cur_ff.latch;
		// Stored protect bit is caught once after reset release
		if (!cur_ff.cpLoaded) begin
			nxt_cur.cpN = nvmRsp.cpNStored;
			nxt_cur.cpLoaded = 1'b1;
		end
		unique case (cur_ff.st)
			serial_prog_pkg::ST_CMD: begin
				if (clkFall) begin
					nxt_cur.cmdSh = {dataS, cur_ff.cmdSh[5:1]};
					nxt_cur.cnt = cur_ff.cnt + 5'h01;
					if (cur_ff.cnt == 5'(serial_prog_pkg::CMD_W - 1)) begin
						nxt_cur.cnt = 5'h00;
						nxt_cur.cmdSh = '0;
						unique case (cmdCode)
							serial_prog_pkg::CMD_LOAD_CFG: begin
								// Frame starts on the programmer's next clock after its gap
								nxt_cur.st = serial_prog_pkg::ST_DATA;
								nxt_cur.isRead = 1'b0;
								nxt_cur.loadCfg = 1'b1;
							end
							serial_prog_pkg::CMD_LOAD_DATA: begin
								nxt_cur.st = serial_prog_pkg::ST_DATA;
								nxt_cur.isRead = 1'b0;
								nxt_cur.loadCfg = 1'b0;
							end
							serial_prog_pkg::CMD_READ_DATA: begin
								nxt_cur.st = serial_prog_pkg::ST_DATA;
								nxt_cur.isRead = 1'b1;
								nxt_cur.loadCfg = 1'b0;
								// Word is captured before the frame, so later rdData changes do not tear it
								if (inProgSpace && protect) begin
									nxt_cur.dataSh = '0;
								end else begin
									nxt_cur.dataSh = nvmRsp.rdData;
								end
							end
							serial_prog_pkg::CMD_INC_ADDR: begin
								// Configuration space is kept while stepping
								nxt_cur.addr = {cur_ff.addr[15], cur_ff.addr[14:0] + 15'h0001};
							end
							serial_prog_pkg::CMD_RESET_ADDR: begin
								nxt_cur.addr = serial_prog_pkg::ADDR_RESET;
							end
							serial_prog_pkg::CMD_BEGIN_INT: begin
								if (intWriteOk) begin
									nxt_cur.req.write = 1'b1;
									nxt_cur.st = serial_prog_pkg::ST_BUSY;
									nxt_cur.busyCnt = PROG_LOAD;
									if (cur_ff.addr == serial_prog_pkg::CFG_WORD1_ADDR) begin
										// Flash only clears bits, so protection never drops here
										nxt_cur.cpN = cur_ff.cpN & cur_ff.latch[serial_prog_pkg::CP_N_POS];
									end
								end
							end
							serial_prog_pkg::CMD_BEGIN_EXT: begin
								if (extWriteOk) begin
									nxt_cur.req.write = 1'b1;
									nxt_cur.extActive = 1'b1;
								end
							end
							serial_prog_pkg::CMD_END_EXT: begin
								nxt_cur.extActive = 1'b0;
							end
							serial_prog_pkg::CMD_BULK_ERASE: begin
								nxt_cur.req.bulkErase = 1'b1;
								nxt_cur.cpN = serial_prog_pkg::CP_N_RESET;
								nxt_cur.st = serial_prog_pkg::ST_BUSY;
								nxt_cur.busyCnt = BULK_LOAD;
							end
							serial_prog_pkg::CMD_ROW_ERASE: begin
								if (inProgSpace && !protect) begin
									nxt_cur.req.rowErase = 1'b1;
									nxt_cur.st = serial_prog_pkg::ST_BUSY;
									nxt_cur.busyCnt = ROW_LOAD;
								end
							end
							default: begin
								// Unknown codes are ignored
								nxt_cur.st = serial_prog_pkg::ST_CMD;
							end
						endcase
					end
				end
			end
			serial_prog_pkg::ST_DATA: begin
				if (clkFall) begin
					nxt_cur.cnt = cur_ff.cnt + 5'h01;
					if (cur_ff.isRead) begin
						if (cur_ff.cnt == 5'h00) begin
							nxt_cur.dOe = 1'b1;
							nxt_cur.dOut = 1'b0;
						end
					end else if (cur_ff.cnt != 5'h00 && cur_ff.cnt <= serial_prog_pkg::FRAME_LAST_BIT) begin
						nxt_cur.dataSh = {dataS, cur_ff.dataSh[13:1]};
					end
					if (cur_ff.cnt == serial_prog_pkg::FRAME_LAST_FALL) begin
						nxt_cur.cnt = 5'h00;
						nxt_cur.st = serial_prog_pkg::ST_CMD;
						nxt_cur.dOe = 1'b0;
						nxt_cur.dOut = 1'b0;
						if (!cur_ff.isRead) begin
							nxt_cur.latch = cur_ff.dataSh;
							if (cur_ff.loadCfg) begin
								nxt_cur.addr = serial_prog_pkg::CFG_BASE;
							end
						end
					end
				end else if (clkRise && cur_ff.isRead && cur_ff.dOe) begin
					// Rise number cnt+1; bits go out on rises 2 to 15, stop bit on 16
					if (cur_ff.cnt != 5'h00 && cur_ff.cnt <= serial_prog_pkg::FRAME_LAST_BIT) begin
						nxt_cur.dOut = cur_ff.dataSh[0];
						nxt_cur.dataSh = {1'b0, cur_ff.dataSh[13:1]};
					end else begin
						nxt_cur.dOut = 1'b0;
					end
				end
			end
			serial_prog_pkg::ST_BUSY: begin
				// Clock edges during erase or programming are ignored
				if (cur_ff.busyCnt == '0) begin
					nxt_cur.st = serial_prog_pkg::ST_CMD;
				end else begin
					nxt_cur.busyCnt = cur_ff.busyCnt - serial_prog_pkg::BUSY_W'(1);
				end
			end
			default: begin
				nxt_cur.st = serial_prog_pkg::ST_CMD;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			cur_ff <= '{
				st: serial_prog_pkg::ST_CMD,
				clkPrev: 1'b0,
				cmdSh: '0,
				cnt: 5'h00,
				dataSh: '0,
				isRead: 1'b0,
				loadCfg: 1'b0,
				addr: serial_prog_pkg::ADDR_RESET,
				latch: '0,
				cpN: serial_prog_pkg::CP_N_RESET,
				cpLoaded: 1'b0,
				extActive: 1'b0,
				busyCnt: '0,
				dOut: 1'b0,
				dOe: 1'b0,
				req: '0
			};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign serialProgDataPinOut = cur_ff.dOut;
	assign serialProgDataPinOe = cur_ff.dOe;
	assign progBusy = cur_ff.st == serial_prog_pkg::ST_BUSY;
	assign nvmReq = cur_ff.req;

endmodule

// [serial_prog_port_monitor.sv]
// Purpose: Port assertions for serial_prog_port
// Assumes: Bound to the top module
// Notes: Busy length is counted in helper logic
module serial_prog_port_monitor #(
	parameter int BULK_CYCLES = 50
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic serialProgClockPin,
	input wire logic serialProgDataPinOut,
	input wire logic serialProgDataPinOe,
	input wire logic progBusy,
	input wire serial_prog_pkg::nvm_req_s nvmReq
);
	int busyLen;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk) begin
		busyLen <= (rst_n && progBusy) ? busyLen + 1 : 0;
	end
	a_write_one_pulse: assert property (nvmReq.write |=> !nvmReq.write)
		else $error("write pulse too long");
	a_busy_after_erase: assert property ((nvmReq.bulkErase || nvmReq.rowErase) |-> progBusy)
		else $error("no busy with erase");
	a_busy_has_cause: assert property ($rose(progBusy) |-> (nvmReq.write || nvmReq.bulkErase || nvmReq.rowErase))
		else $error("busy without request");
	a_busy_bound: assert property (busyLen <= BULK_CYCLES + 1)
		else $error("busy too long");
	a_quiet_busy: assert property (progBusy |-> !serialProgDataPinOe)
		else $error("pin driven while busy");
	a_oe_at_fall: assert property ($changed(serialProgDataPinOe) |-> !serialProgClockPin)
		else $error("drive change off falling edge");
	a_out_at_rise: assert property ($changed(serialProgDataPinOut) |-> serialProgClockPin)
		else $error("data change off rising edge");
	a_addr_hold_busy: assert property (progBusy |-> $stable(nvmReq.addr))
		else $error("address moved while busy");
	a_one_pulse_kind: assert property ($onehot0({nvmReq.write, nvmReq.bulkErase, nvmReq.rowErase}))
		else $error("two memory requests at once");
	c_read: cover property ($rose(serialProgDataPinOe));
	c_write: cover property (nvmReq.write);
	c_erase: cover property (nvmReq.bulkErase);
endmodule

bind serial_prog_port serial_prog_port_monitor #(.BULK_CYCLES(BULK_CYCLES)) mon (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.serialProgClockPin(serialProgClockPin),
	.serialProgDataPinOut(serialProgDataPinOut),
	.serialProgDataPinOe(serialProgDataPinOe),
	.progBusy(progBusy),
	.nvmReq(nvmReq)
);

// [nvm_model.sv]
// Purpose: Flash array behind the serial port
// Assumes: Reads answer combinationally
// Notes: Erased cells read all ones
module nvm_model (
	input wire logic ref_clk,
	input wire serial_prog_pkg::nvm_req_s nvmReq,
	output serial_prog_pkg::nvm_rsp_s nvmRsp
);
	logic [13:0] mem [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 14'h3fff;
		end
	end
	assign nvmRsp.rdData = mem[nvmReq.addr];
	assign nvmRsp.cpNStored = mem[16'h8007][7];
	always @(posedge ref_clk) begin
		if (nvmReq.write) begin
			mem[nvmReq.addr] <= nvmReq.wrData;
		end
		if (nvmReq.bulkErase) begin
			for (int i = 0; i < 32768; i++) begin
				mem[i] <= 14'h3fff;
			end
			mem[16'h8007] <= 14'h3fff;
		end
		// Row of 32 words is a model choice
		if (nvmReq.rowErase) begin
			for (int i = 0; i < 32; i++) begin
				mem[{nvmReq.addr[15:5], 5'(i)}] <= 14'h3fff;
			end
		end
	end
endmodule

// [serial_program_verify_port_bench.sv]
// Purpose: Self-checking bench for the serial program/verify port
// Assumes: Program and erase times shortened by parameters
// Notes: Bench plays the external programmer
module serial_program_verify_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0;
	logic rst_n = 0;
	logic modeOn = 0;
	logic sclk = 0;
	logic sdi = 0;
	logic dOut, dOe, busy, pinIn;
	serial_prog_pkg::nvm_req_s req;
	serial_prog_pkg::nvm_rsp_s rsp;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int writes = 0;
	int busyCyc = 0;
	int oeCyc = 0;
	always #2 ref_clk = ~ref_clk;
	assign pinIn = dOe ? dOut : sdi;
	serial_prog_port #(.BULK_CYCLES(50), .ROW_CYCLES(30), .PROG_CYCLES(20)) uut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.progModeActive(modeOn),
		.serialProgClockPin(sclk),
		.serialProgDataPinIn(pinIn),
		.serialProgDataPinOut(dOut),
		.serialProgDataPinOe(dOe),
		.progBusy(busy),
		.nvmReq(req),
		.nvmRsp(rsp)
	);
	nvm_model flash (.ref_clk(ref_clk), .nvmReq(req), .nvmRsp(rsp));
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		writes <= writes + 32'(req.write);
		busyCyc <= busyCyc + 32'(busy);
		oeCyc <= oeCyc + 32'(dOe);
		if (cyc == 40000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input logic b, output logic o);
		sclk = 1;
		sdi = b;
		repeat (8) @(negedge ref_clk);
		o = dOut;
		sclk = 0;
		repeat (8) @(negedge ref_clk);
	endtask
	// Gap also covers the longest shortened erase time
	task automatic gap();
		sdi = ~sdi;
		repeat (300) @(negedge ref_clk);
	endtask
	task automatic cmd(input logic [5:0] c);
		logic o;
		for (int i = 0; i < 6; i++) tick(c[i], o);
		gap();
	endtask
	task automatic frame(input logic [13:0] w, output logic [13:0] r);
		logic o;
		logic [15:0] f;
		f = {1'b0, w, 1'b0};
		for (int i = 0; i < 16; i++) begin
			tick(f[i], o);
			if (i > 0 && i < 15) r = {o, r[13:1]};
		end
		gap();
	endtask
	task automatic readw(output logic [13:0] r);
		int o0;
		o0 = oeCyc;
		cmd(6'h04);
		frame(14'h0000, r);
		chk("drive length", 1'b1, (oeCyc - o0) inside {[239:241]});
	endtask
	task automatic t_program();
		logic [13:0] r;
		cmd(6'h16);
		chk("addr", 16'h0000, req.addr);
		cmd(6'h02);
		frame(14'h2a5c, r);
		chk("latch", 16'h2a5c, req.wrData);
		chk("no early write", 16'h0000, 16'(writes));
		cmd(6'h08);
		readw(r);
		chk("word0", 16'h2a5c, r);
		$display("program test done");
	endtask
	task automatic t_config();
		logic [13:0] r;
		cmd(6'h00);
		frame(14'h1234, r);
		chk("cfg addr", 16'h8000, req.addr);
		chk("cfg latch", 16'h1234, req.wrData);
		cmd(6'h08);
		for (int i = 0; i < 7; i++) cmd(6'h06);
		cmd(6'h02);
		frame(14'h3f7f, r);
		cmd(6'h18);
		readw(r);
		chk("ext cfg", 16'h3fff, r);
		cmd(6'h08);
		readw(r);
		chk("int cfg", 16'h3f7f, r);
		chk("addr kept", 16'h8007, req.addr);
		$display("config test done");
	endtask
	task automatic t_protect();
		logic [13:0] r;
		int n;
		n = writes;
		cmd(6'h16);
		readw(r);
		chk("protected read", 16'h0000, r);
		cmd(6'h02);
		frame(14'h1111, r);
		cmd(6'h08);
		chk("refused write", 16'(n), 16'(writes));
		cmd(6'h00);
		frame(14'h0000, r);
		readw(r);
		chk("user id", 16'h1234, r);
		$display("protect test done");
	endtask
	task automatic t_erase();
		logic [13:0] r;
		int b;
		b = busyCyc;
		cmd(6'h09);
		chk("erase busy", 1'b1, (busyCyc - b) inside {[50:51]});
		cmd(6'h16);
		readw(r);
		chk("erased read", 16'h3fff, r);
		$display("erase test done");
	endtask
	task automatic t_row();
		logic [13:0] r;
		int b;
		int n;
		n = writes;
		cmd(6'h16);
		cmd(6'h02);
		frame(14'h0155, r);
		cmd(6'h18);
		cmd(6'h0a);
		chk("ext write", 16'(n + 1), 16'(writes));
		readw(r);
		chk("ext word", 16'h0155, r);
		b = busyCyc;
		cmd(6'h11);
		chk("row busy", 1'b1, (busyCyc - b) inside {[30:31]});
		readw(r);
		chk("row erased", 16'h3fff, r);
		cmd(6'h00);
		frame(14'h0000, r);
		chk("cfg again", 16'h8000, req.addr);
		modeOn = 0;
		repeat (10) @(negedge ref_clk);
		modeOn = 1;
		repeat (10) @(negedge ref_clk);
		chk("exit addr", 16'h0000, req.addr);
		$display("row and exit test done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1;
		modeOn = 1;
		repeat (10) @(negedge ref_clk);
		t_program();
		t_config();
		t_protect();
		t_erase();
		t_row();
		end_of_test();
	end
endmodule
